// *** core/xfer_ctl.sv ***
// Event-triggered byte transfer controller with AXI4-Lite registers
`timescale 1ns/1ps

module xfer_ctl
  import xfer_ctl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [47:0] src_event_i,
  output logic [47:0] irq_req_o,
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [15:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic mem_ack_i
);

  // ****************************************
  // Helpers
  // ****************************************
  // Register index to enable slot; 3'h7 marks no enable register
  function automatic logic [2:0] slot_of(input logic [7:0] idx);
    case (idx)
      IDX_ENABLE_0: slot_of = 3'h0;
      IDX_ENABLE_1: slot_of = 3'h1;
      IDX_ENABLE_2: slot_of = 3'h2;
      IDX_ENABLE_3: slot_of = 3'h3;
      IDX_ENABLE_5: slot_of = 3'h4;
      IDX_ENABLE_6: slot_of = 3'h5;
      default: slot_of = 3'h7;
    endcase
  endfunction

  // Zero stands for 256
  function automatic logic [8:0] ext9(input logic [7:0] v);
    ext9 = (v == 8'h00) ? 9'h100 : {1'b0, v};
  endfunction

  function automatic logic [15:0] cd_addr(input logic [4:0] set,
                                          input logic [2:0] b);
    cd_addr = CD_BASE + {8'h00, set, b};
  endfunction

  // Control set number: rank of the source among existing sources
  function automatic logic [4:0] set_of(input logic [5:0] src);
    logic [4:0] n;
    n = 5'h00;
    for (int i = 0; i < 48; i++) begin
      if (SRC_VALID[i] && (i < int'(src))) begin
        n = n + 5'h01;
      end
    end
    set_of = n;
  endfunction

  ctl_state_t s, next_s;
  logic [47:0] ready_req;
  logic rpt;
  logic inc_src;
  logic inc_dst;
  logic last_byte;
  logic [15:0] rewind;
  logic [17:0] rewind_full;
  logic [7:0] wb_byte;
  logic [2:0] wslot;
  logic [2:0] rslot;
  logic [5:0] pick;
  logic pick_ok;

  // ****************************************
  // Control field decode
  // ****************************************
  always_comb begin
    rpt = s.ccr[F_MODE];
    // Repeat side always steps; the other side obeys its own bit
    inc_src = (rpt & s.ccr[F_RPT_AREA]) | s.ccr[F_SSTEP];
    inc_dst = (rpt & !s.ccr[F_RPT_AREA]) | s.ccr[F_DSTEP];
    last_byte = (s.left == 9'h001);
    // Bytes moved by a full repeat cycle, assuming count started at reload
    rewind_full = 18'(ext9(s.blk)) * 18'(ext9(s.rld));
    rewind = rewind_full[15:0];
    case (s.bcnt + 3'h1) // Byte after the one being written back
      3'h0: wb_byte = s.ccr;
      3'h1: wb_byte = s.blk;
      3'h2: wb_byte = s.cnt;
      3'h3: wb_byte = s.rld;
      3'h4: wb_byte = s.sar[7:0];
      3'h5: wb_byte = s.sar[15:8];
      3'h6: wb_byte = s.dar[7:0];
      default: wb_byte = s.dar[15:8];
    endcase
    ready_req = s.pend & s.en & SRC_VALID;
    pick = 6'h00;
    pick_ok = 1'b0;
    // Lowest bit wins; a fixed priority, not the device's own order
    for (int i = 47; i >= 0; i--) begin
      if (ready_req[i]) begin
        pick = 6'(i);
        pick_ok = 1'b1;
      end
    end
    wslot = slot_of(s.aw_idx);
    rslot = slot_of(s_axi_araddr_i[9:2]);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_s = s;
    next_s.irq = 48'h0;
    // A new event beats the clear of its own pending bit
    next_s.pend = s.pend | (src_event_i & s.en & SRC_VALID);

    // AXI write channel
    if (s.awready && s_axi_awvalid_i) begin
      next_s.awready = 1'b0;
      next_s.aw_ok = 1'b1;
      next_s.aw_idx = s_axi_awaddr_i[9:2];
    end
    if (s.wready && s_axi_wvalid_i) begin
      next_s.wready = 1'b0;
      next_s.w_ok = 1'b1;
      next_s.wdata = s_axi_wdata_i[7:0];
      next_s.wstrb0 = s_axi_wstrb_i[0];
    end
    if (s.aw_ok && s.w_ok && !s.bvalid) begin
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (wslot != 3'h7) begin
        if (s.wstrb0) begin
          next_s.en[8*wslot +: 8] = s.wdata;
        end
      end else if (s.aw_idx != IDX_STATUS) begin
        next_s.bresp = RESP_SLVERR;
      end
    end
    if (s.bvalid && s_axi_bready_i) begin
      next_s.bvalid = 1'b0;
      next_s.aw_ok = 1'b0;
      next_s.w_ok = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready = 1'b1;
    end

    // AXI read channel
    if (s.arready && s_axi_arvalid_i) begin
      next_s.arready = 1'b0;
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = 32'h0;
      if (rslot != 3'h7) begin
        next_s.rdata[7:0] = s.en[8*rslot +: 8];
      end else if (s_axi_araddr_i[9:2] == IDX_STATUS) begin
        next_s.rdata[8] = (s.st != st_idle);
        next_s.rdata[4:0] = s.set;
      end else begin
        next_s.rresp = RESP_SLVERR;
      end
    end
    if (s.rvalid && s_axi_rready_i) begin
      next_s.rvalid = 1'b0;
      next_s.arready = 1'b1;
    end

    // Transfer engine
    case (s.st)
      st_idle: begin
        if (pick_ok) begin
          next_s.pend[pick] = src_event_i[pick] & s.en[pick];
          next_s.src = pick;
          next_s.set = set_of(pick);
          next_s.first = 1'b1;
          next_s.fire = 1'b0;
          next_s.bcnt = 3'h0;
          next_s.mreq = 1'b1;
          next_s.mwe = 1'b0;
          next_s.maddr = cd_addr(set_of(pick), 3'h0);
          next_s.st = st_load;
        end
      end
      st_load: begin
        if (mem_ack_i) begin
          case (s.bcnt)
            3'h0: next_s.ccr = mem_rdata_i;
            3'h1: next_s.blk = mem_rdata_i;
            3'h2: next_s.cnt = mem_rdata_i;
            3'h3: next_s.rld = mem_rdata_i;
            3'h4: next_s.sar[7:0] = mem_rdata_i;
            3'h5: next_s.sar[15:8] = mem_rdata_i;
            3'h6: next_s.dar[7:0] = mem_rdata_i;
            default: next_s.dar[15:8] = mem_rdata_i;
          endcase
          if (s.bcnt == CD_LAST_BYTE) begin
            next_s.left = ext9(s.blk);
            next_s.maddr = {s.sar[15:8], s.sar[7:0]};
            next_s.st = st_read;
          end else begin
            next_s.bcnt = s.bcnt + 3'h1;
            next_s.maddr = cd_addr(s.set, s.bcnt + 3'h1);
          end
        end
      end
      st_read: begin
        if (mem_ack_i) begin
          next_s.mwe = 1'b1;
          next_s.mwdata = mem_rdata_i;
          next_s.maddr = s.dar;
          next_s.st = st_write;
        end
      end
      st_write: begin
        if (mem_ack_i) begin
          if (inc_src) begin
            next_s.sar = s.sar + 16'h0001;
          end
          if (inc_dst) begin
            next_s.dar = s.dar + 16'h0001;
          end
          next_s.left = s.left - 9'h001;
          if (last_byte) begin
            next_s.cnt = s.cnt - 8'h01;
            if (s.cnt == 8'h01) begin
              if (s.first) begin
                // Only the first set of a chain decides the ending
                next_s.fire = !rpt || s.ccr[F_RPT_IRQ];
              end
              if (rpt) begin
                next_s.cnt = s.rld;
                if (s.ccr[F_RPT_AREA]) begin
                  next_s.sar = s.sar + 16'h0001 - rewind;
                end else begin
                  next_s.dar = s.dar + 16'h0001 - rewind;
                end
              end
            end
            next_s.bcnt = 3'h0;
            next_s.st = st_wback;
            next_s.maddr = cd_addr(s.set, 3'h0);
            next_s.mwdata = s.ccr;
          end else begin
            next_s.mwe = 1'b0;
            next_s.maddr = inc_src ? s.sar + 16'h0001 : s.sar;
            next_s.st = st_read;
          end
        end
      end
      st_wback: begin
        if (mem_ack_i) begin
          if (s.bcnt != CD_LAST_BYTE) begin
            next_s.bcnt = s.bcnt + 3'h1;
            next_s.mwdata = wb_byte;
            next_s.maddr = cd_addr(s.set, s.bcnt + 3'h1);
          end else if (s.ccr[F_CHAIN] && (s.set != LAST_SET)) begin
            next_s.set = s.set + 5'h01;
            next_s.first = 1'b0;
            next_s.bcnt = 3'h0;
            next_s.mwe = 1'b0;
            next_s.maddr = cd_addr(s.set + 5'h01, 3'h0);
            next_s.st = st_load;
          end else begin
            next_s.mreq = 1'b0;
            next_s.mwe = 1'b0;
            next_s.st = st_idle;
            if (s.fire) begin
              next_s.irq[s.src] = 1'b1;
              // Hardware clear wins over a software write here
              next_s.en[s.src] = 1'b0;
            end
          end
        end
      end
      default: begin
        next_s.st = st_idle;
        next_s.mreq = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
      s.en <= {6{ENABLE_RESET}};
      s.st <= st_idle;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o = s.wready;
  assign s_axi_bvalid_o = s.bvalid;
  assign s_axi_bresp_o = s.bresp;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rvalid_o = s.rvalid;
  assign s_axi_rdata_o = s.rdata;
  assign s_axi_rresp_o = s.rresp;
  assign irq_req_o = s.irq;
  assign mem_req_o = s.mreq;
  assign mem_we_o = s.mwe;
  assign mem_addr_o = s.maddr;
  assign mem_wdata_o = s.mwdata;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_block_end;
    s.st == st_write && mem_ack_i && last_byte;
  endsequence

  sequence s_wb_last;
    s.st == st_wback && mem_ack_i && s.bcnt == CD_LAST_BYTE;
  endsequence

  a_pend_kept: assert property ((s.st != st_idle) |=>
    ((s.pend & $past(s.pend)) == $past(s.pend)))
    else $error("pending request lost");
  a_blk_len: assert property ((s.st == st_load && mem_ack_i &&
    s.bcnt == CD_LAST_BYTE) |=> s.left == ext9($past(s.blk)))
    else $error("block length wrong");
  a_src_fixed: assert property ((s.st == st_write && mem_ack_i &&
    !inc_src && !(last_byte && rpt)) |=> $stable(s.sar))
    else $error("fixed source moved");
  a_dst_step: assert property ((s.st == st_write && mem_ack_i &&
    inc_dst && !(last_byte && rpt)) |=> s.dar == $past(s.dar) + 16'h0001)
    else $error("destination did not step");
  a_cnt_dec: assert property ((s_block_end and !rpt) |=>
    s.cnt == $past(s.cnt) - 8'h01)
    else $error("count not decremented");
  a_cnt_reload: assert property ((s_block_end and rpt &&
    s.cnt == 8'h01) |=> s.cnt == $past(s.rld))
    else $error("count not reloaded");
  a_chain_next: assert property ((s_wb_last and s.ccr[F_CHAIN] &&
    s.set != LAST_SET) |=> s.set == $past(s.set) + 5'h01 && s.st == st_load)
    else $error("chain did not advance");
  a_irq_clear: assert property ((|s.irq) |->
    ((s.irq & s.en) == 48'h0 && s.st == st_idle))
    else $error("enable kept after final transfer");
  a_irq_once: assert property ((|s.irq) |=> !(|s.irq))
    else $error("interrupt request not a pulse");
  a_mreq_hold: assert property ((s.mreq && !mem_ack_i) |=>
    (s.mreq && $stable(s.maddr) && $stable(s.mwdata)))
    else $error("memory request dropped");
  a_bvalid_hold: assert property (s.bvalid && !s_axi_bready_i |=>
    s.bvalid)
    else $error("write response dropped");

endmodule

// *** core/xfer_ctl_pkg.sv ***
// Package: constants, types and state for the transfer controller
package xfer_ctl_pkg;

  // ****************************************
  // Register map (indices; byte address is index times four)
  // ****************************************
  localparam logic [7:0] IDX_ENABLE_0 = 8'h88;
  localparam logic [7:0] IDX_ENABLE_1 = 8'h89;
  localparam logic [7:0] IDX_ENABLE_2 = 8'h8a;
  localparam logic [7:0] IDX_ENABLE_3 = 8'h8b;
  localparam logic [7:0] IDX_ENABLE_5 = 8'h8d;
  localparam logic [7:0] IDX_ENABLE_6 = 8'h8e;
  localparam logic [7:0] IDX_STATUS = 8'h90;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Control data layout
  // ****************************************
  localparam logic [15:0] CD_BASE = 16'h2c40;
  localparam int CD_BYTES = 8;
  localparam logic [4:0] LAST_SET = 5'h17;
  localparam logic [2:0] CD_LAST_BYTE = 3'h7;
  localparam int F_MODE = 0;
  localparam int F_RPT_AREA = 1;
  localparam int F_SSTEP = 2;
  localparam int F_DSTEP = 3;
  localparam int F_CHAIN = 4;
  localparam int F_RPT_IRQ = 5;

  // Sources that really exist, one bit per enable bit
  localparam logic [47:0] SRC_VALID = 48'h58_20_c0_f3_f3_d0;

  typedef enum logic [2:0] {
    st_idle,
    st_load,
    st_read,
    st_write,
    st_wback
  } xfer_state_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_ok;
    logic w_ok;
    logic [7:0] aw_idx;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [47:0] en;
    logic [47:0] pend;
    logic [47:0] irq;
    xfer_state_t st;
    logic [2:0] bcnt;
    logic [5:0] src;
    logic [4:0] set;
    logic first;
    logic fire;
    logic [7:0] ccr;
    logic [7:0] blk;
    logic [7:0] cnt;
    logic [7:0] rld;
    logic [15:0] sar;
    logic [15:0] dar;
    logic [8:0] left;
    logic mreq;
    logic mwe;
    logic [15:0] maddr;
    logic [7:0] mwdata;
  } ctl_state_t;

endpackage

// *** bench/mem_bus_model.sv ***
// Byte memory answering the controller's bus, promptly or slowly
`timescale 1ns/1ps
module mem_bus_model (
  input wire logic sys_clk_i,
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic [1:0] delay_i,
  output logic [7:0] mem_rdata_o,
  output logic mem_ack_o
);
  logic [7:0] store [0:65535];
  logic [7:0] last = 8'h00;
  logic [1:0] wait_n = 2'h0;
  logic ack = 1'h0;
  assign mem_ack_o = ack;
  // Junk between answers, so a stale byte is never taken for data
  assign mem_rdata_o = ack ? last : ~last;
  always @(posedge sys_clk_i) begin
    ack <= 1'h0;
    if (mem_req_i && !ack) begin
      if (wait_n >= delay_i) begin
        wait_n <= 2'h0;
        ack <= 1'h1;
        if (mem_we_i) begin
          store[mem_addr_i] <= mem_wdata_i;
        end else begin
          last <= store[mem_addr_i];
        end
      end else begin
        wait_n <= wait_n + 2'h1;
      end
    end
  end
endmodule

// *** bench/event_triggered_transfer_control_tb.sv ***
// Self-checking bench for the event-triggered transfer controller
`timescale 1ns/1ps
module event_triggered_transfer_control_tb;
  import xfer_ctl_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic [47:0] ev = 48'h0;
  logic [1:0] dly = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, mreq, mwe, mack;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [47:0] irq;
  logic [15:0] maddr;
  logic [7:0] mwdata, mrdata;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int irq_n [48] = '{default: 0};

  xfer_ctl xfer_ctl_inst (.sys_clk_i(clk), .resetn_i(rst_n),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'h1), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'h1),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(1'h1), .src_event_i(ev), .irq_req_o(irq),
    .mem_req_o(mreq), .mem_we_o(mwe), .mem_addr_o(maddr),
    .mem_wdata_o(mwdata), .mem_rdata_i(mrdata), .mem_ack_i(mack));

  mem_bus_model mem_bus_model_inst (.sys_clk_i(clk), .mem_req_i(mreq),
    .mem_we_i(mwe), .mem_addr_i(maddr), .mem_wdata_i(mwdata),
    .delay_i(dly), .mem_rdata_o(mrdata), .mem_ack_o(mack));

  initial begin
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Monitors and shared tasks
  // ****************************************
  always @(posedge clk) begin
    cyc++;
    for (int i = 0; i < 48; i++) begin
      if (irq[i] === 1'h1) irq_n[i]++;
    end
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test;
    end
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready lines stay high, so each answer is taken where it appears
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    r = bresp;
  endtask

  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask

  task automatic chk_en(input logic [7:0] e);
    rd({2'h0, IDX_ENABLE_0, 2'h0});
    chk("read resp", RESP_OKAY, r);
    chk("enable 0", {24'h0, e}, d);
  endtask

  function automatic logic [7:0] mb(input int a);
    return mem_bus_model_inst.store[a[15:0]];
  endfunction

  function automatic logic [15:0] cd(input int s, k);
    return {mb(CD_BASE + 8 * s + k + 1), mb(CD_BASE + 8 * s + k)};
  endfunction

  task automatic set_cd(input int s, input logic [7:0] c, b, n,
                        input logic [15:0] sa, da);
    int a;
    a = CD_BASE + 8 * s;
    {mem_bus_model_inst.store[a + 3], mem_bus_model_inst.store[a + 2],
     mem_bus_model_inst.store[a + 1], mem_bus_model_inst.store[a]}
      = {n, n, b, c};
    {mem_bus_model_inst.store[a + 7], mem_bus_model_inst.store[a + 6],
     mem_bus_model_inst.store[a + 5], mem_bus_model_inst.store[a + 4]}
      = {da, sa};
  endtask

  task automatic fire(input int b);
    ev[b] <= 1'h1;
    @(posedge clk);
    ev[b] <= 1'h0;
  endtask

  task automatic settle;
    int q;
    q = 0;
    while (q < 20) begin
      @(posedge clk);
      q = mreq ? 0 : q + 1;
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs;
    logic [7:0] ids [6];
    ids = '{IDX_ENABLE_0, IDX_ENABLE_1, IDX_ENABLE_2, IDX_ENABLE_3,
            IDX_ENABLE_5, IDX_ENABLE_6};
    for (int k = 0; k < 6; k++) begin
      rd({2'h0, ids[k], 2'h0});
      chk("enable reset", 32'h0, d);
      wr({2'h0, ids[k], 2'h0}, 8'h3c + 8'(k));
      chk("write resp", RESP_OKAY, r);
      rd({2'h0, ids[k], 2'h0});
      chk("enable readback", 32'h3c + k, d);
      wr({2'h0, ids[k], 2'h0}, 8'h00);
    end
    wr(12'h100, 8'h55);
    chk("unmapped write", RESP_SLVERR, r);
    rd(12'h100);
    chk("unmapped read", RESP_SLVERR, r);
    chk("unmapped data", 32'h0, d);
  endtask

  task automatic t_normal;
    // Repeat-only fields set on purpose; normal mode must ignore them
    set_cd(0, 8'h2e, 8'h03, 8'h01, 16'h1000, 16'h2000);
    fire(4);
    settle;
    chk("blocked count", 8'h01, cd(0, 2) & 16'hff);
    wr({2'h0, IDX_ENABLE_0, 2'h0}, 8'hd0);
    fire(4);
    settle;
    for (int k = 0; k < 3; k++) begin
      chk("copied byte", 8'ha1 + k, mb(16'h2000 + k));
    end
    chk("count", 8'h00, cd(0, 2) & 16'hff);
    chk("source", 16'h1003, cd(0, 4));
    chk("dest", 16'h2003, cd(0, 6));
    chk("irq 4", 1, irq_n[4]);
    chk_en(8'hc0);
  endtask

  task automatic t_wrap;
    dly <= 2'h2;
    wr({2'h0, IDX_ENABLE_0, 2'h0}, 8'hd0);
    set_cd(0, 8'h0c, 8'h00, 8'h00, 16'h3000, 16'hfff0);
    for (int k = 0; k < 256; k++) begin
      mem_bus_model_inst.store[16'h3000 + k] = 8'(k);
    end
    fire(4);
    settle;
    chk("last byte", 8'hff, mb(16'h00ef));
    chk("dest wrap", 16'h00f0, cd(0, 6));
    chk("source", 16'h3100, cd(0, 4));
    chk("count", 8'hff, cd(0, 2) & 16'hff);
    chk("irq 4", 1, irq_n[4]);
    chk_en(8'hd0);
  endtask

  task automatic t_repeat;
    dly <= 2'h0;
    // Destination is the repeat side and its step bit is left at fixed
    set_cd(1, 8'h25, 8'h02, 8'h01, 16'h1000, 16'h4000);
    fire(6);
    settle;
    chk("rpt byte 1", 8'ha2, mb(16'h4001));
    chk("dest restored", 16'h4000, cd(1, 6));
    chk("source", 16'h1002, cd(1, 4));
    chk("reloaded", 8'h01, cd(1, 2) & 16'hff);
    chk("irq 6", 1, irq_n[6]);
    chk_en(8'h90);
  endtask

  task automatic t_chain;
    dly <= 2'h1;
    wr({2'h0, IDX_ENABLE_0, 2'h0}, 8'hd0);
    set_cd(0, 8'h18, 8'h02, 8'h03, 16'h1000, 16'h5000);
    // Chain off where the chain ends
    set_cd(1, 8'h04, 8'h02, 8'h02, 16'h1000, 16'h6000);
    fire(4);
    repeat (3) @(posedge clk);
    fire(6);
    settle;
    chk("fixed source", 8'ha1, mb(16'h5001));
    chk("set 0 source", 16'h1000, cd(0, 4));
    chk("set 0 count", 8'h02, cd(0, 2) & 16'hff);
    chk("fixed dest", 8'ha4, mb(16'h6000));
    chk("set 1 source", 16'h1004, cd(1, 4));
    chk("set 1 count", 8'h00, cd(1, 2) & 16'hff);
    chk("irq 6", 2, irq_n[6]);
    chk("irq 4", 1, irq_n[4]);
    chk_en(8'h90);
    // Status: idle, last set served is set 1
    rd({2'h0, IDX_STATUS, 2'h0});
    chk("status", 32'h1, d);
  endtask

  initial begin
    for (int k = 0; k < 4; k++) begin
      mem_bus_model_inst.store[16'h1000 + k] = 8'ha1 + 8'(k);
    end
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs;
    t_normal;
    t_wrap;
    t_repeat;
    t_chain;
    end_of_test;
  end
endmodule
